// >>> shared/pci_cfg_tail_pkg.sv
// Constants and types for the configuration header tail registers
package pci_cfg_tail_pkg;
	// Doubleword indices within configuration space
	typedef logic [5:0] dw_index_t;
	localparam dw_index_t DW_CARD_PTR = 6'h0A;
	localparam dw_index_t DW_SUBSYS = 6'h0B;
	localparam dw_index_t DW_ROM_BASE = 6'h0C;
	localparam dw_index_t DW_CAP_PTR = 6'h0D;
	localparam dw_index_t DW_IRQ = 6'h0F;
	localparam dw_index_t DW_LOCAL_START = 6'h10;

	// Card information structure pointer fields
	localparam int CARD_SPACE_LSB = 0;
	localparam int CARD_SPACE_MSB = 2;
	localparam int CARD_OFFSET_LSB = 3;
	localparam int CARD_OFFSET_MSB = 27;
	localparam int CARD_ROM_IMAGE_LSB = 28;
	localparam int CARD_ROM_IMAGE_MSB = 31;
	localparam logic [2:0] CARD_SPACE_CONFIG = 3'h0;

	// Option ROM base fields
	localparam int ROM_ENA_BIT = 0;
	localparam int ROM_BASE_LSB = 11;
	localparam logic [31:0] ROM_MAX_SIZE_MASK = 32'hFF00_0000;
	localparam logic [31:0] ROM_LOW_MASK = 32'h0000_07FF;

	// Byte lanes of shared doublewords
	localparam int SUBSYS_MAKER_LSB = 0;
	localparam int SUBSYS_CODE_LSB = 16;
	localparam int IRQ_LINE_LSB = 0;
	localparam int IRQ_PIN_LSB = 8;

	// Reset and fixed values
	localparam logic [7:0] IRQ_LINE_RST = 8'h00;
	localparam logic [7:0] IRQ_PIN_INTA = 8'h01;
	localparam logic [7:0] IRQ_PIN_NONE = 8'h00;
	localparam logic [7:0] CAP_PTR_MIN = 8'h40;
	localparam logic [1:0] DW_ALIGN_ZERO = 2'h0;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	localparam logic [31:0] DATA_TIMEOUT = 32'hFFFF_FFFF;
	localparam logic [3:0] BYTE_ENA_ALL = 4'hF;

	// Forwarding sequencer states
	typedef enum logic [1:0] {
		FWD_IDLE = 2'b00,
		FWD_WAIT = 2'b01
	} fwd_state_t;
endpackage

// >>> logic/rom_bar_decoder.sv
// Option ROM base register with its address decoder
`timescale 1ns/1ps
module rom_bar_decoder #(
	parameter bit ROM_ENABLE = 1'b1,
	parameter logic [31:0] ROM_SIZE_MASK = 32'hFFFF_0000,
	parameter bit ROM_HARDWIRE = 1'b0,
	parameter logic [31:0] ROM_HARD_BASE = 32'h000C_0000
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register write
	input wire logic wr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic [3:0] byte_ena_in,
	// Address lookup
	input wire logic lookup_valid_in,
	input wire logic [31:0] lookup_addr_in,
	// Results
	output logic [31:0] value_out,
	output logic hit_out
);
	import pci_cfg_tail_pkg::*;

	localparam logic [31:0] LOW_BITS = ~ROM_SIZE_MASK;
	localparam logic [31:0] LOW_NEXT = LOW_BITS + 32'h0000_0001;
	localparam logic ENA_RST = ROM_HARDWIRE;

	if ((LOW_BITS & LOW_NEXT) != DATA_ZERO) begin : g_gap_chk
		$error("ROM size mask must be ones from bit 31 down");
	end
	if ((ROM_SIZE_MASK & ROM_LOW_MASK) != DATA_ZERO) begin : g_low_chk
		$error("ROM size mask reaches below the base field");
	end
	if ((ROM_SIZE_MASK & ROM_MAX_SIZE_MASK) != ROM_MAX_SIZE_MASK)
	begin : g_max_chk
		$error("ROM window larger than 16 MB");
	end
	if ((ROM_HARD_BASE & ~ROM_SIZE_MASK) != DATA_ZERO) begin : g_hw_chk
		$error("Hardwired ROM base not aligned to its size");
	end

	logic [31:0] base_reg;
	logic ena_reg;
	logic [31:0] eff_base;

	// Only mask bits are ever stored, so size probing reads back the mask
	for (genvar i = 0; i < 4; i++) begin : g_lane
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				base_reg[8*i +: 8] <= 8'h00;
			end else if (wr_in && ROM_ENABLE && !ROM_HARDWIRE &&
				byte_ena_in[i]) begin
				base_reg[8*i +: 8] <= wr_data_in[8*i +: 8] &
					ROM_SIZE_MASK[8*i +: 8];
			end
		end
	end

	// Hardwired base comes up enabled so it claims without setup
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ena_reg <= ENA_RST;
		end else if (wr_in && ROM_ENABLE && byte_ena_in[0]) begin
			ena_reg <= wr_data_in[ROM_ENA_BIT];
		end
	end

	assign eff_base = ROM_HARDWIRE ? (ROM_HARD_BASE & ROM_SIZE_MASK) :
		base_reg;

	always_comb begin
		value_out = DATA_ZERO;
		if (ROM_ENABLE) begin
			value_out = eff_base;
			value_out[ROM_ENA_BIT] = ena_reg;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hit_out <= 1'b0;
		end else begin
			hit_out <= lookup_valid_in && ROM_ENABLE && ena_reg &&
				((lookup_addr_in & ROM_SIZE_MASK) == eff_base);
		end
	end
endmodule

// >>> logic/pci_config_header_tail_regs.sv
// Tail of the type-0 configuration header and capability forwarding
`timescale 1ns/1ps

// Notes on behaviour
// - Optional 32-bit card info structure pointer, read-only to software.
// - Pointer exists only when enabled; its value is a build parameter.
// - Pointer: space indicator bits 2-0, offset 27-3, ROM image 31-28.
// - Pointer may never select configuration space; build check refuses it.
// - Fixed 16-bit subsystem maker code readable; writes ignored.
// - Fixed 16-bit subsystem code readable; not writable.
// - Option ROM base sizes and decodes like a 32-bit base register.
// - ROM base bit 0 writable; 0 ignores ROM space, 1 decodes it.
// - ROM base bits 31-11 writable base address; bits 10-1 reserved.
// - ROM window never above 16 MB; size check enforces this.
// - Hardwired option claims ROM accesses at built-in base without setup.
// - Hardwired base bits read-only; bit 0 stays writable to disable.
// - Optional fixed 8-bit capability pointer to first capability.
// - Capability pointer at least 0x40 and doubleword aligned.
// - Accesses at or above 0x40 go to local side as 32-bit transfers; writes pass on the engine's byte enables.
// - 8-bit read/write interrupt routing line, reset 0x00.
// - Read-only interrupt pin register reads 0x01 for line A.
// - Interrupt pin register reads 0x00 when interrupts disabled.
// - Writes to hardwired base complete normally; reads give fixed value.
// - Writable base bits equal contiguous ones of size mask from bit 31.
module pci_config_header_tail_regs #(
	parameter bit CARD_PTR_ENABLE = 1'b0,
	parameter logic [31:0] CARD_PTR_VALUE = 32'h0000_0001,
	// Arbitrary neutral identity values
	parameter logic [15:0] SUBSYS_MAKER_CODE = 16'h5A5A,
	parameter logic [15:0] SUBSYS_CODE = 16'hA5A5,
	parameter bit ROM_ENABLE = 1'b1,
	parameter logic [31:0] ROM_SIZE_MASK = 32'hFFFF_0000,
	parameter bit ROM_HARDWIRE = 1'b0,
	parameter logic [31:0] ROM_HARD_BASE = 32'h000C_0000,
	parameter bit CAP_ENABLE = 1'b0,
	parameter logic [7:0] CAP_PTR_VALUE = 8'h40,
	parameter bit IRQ_ENABLE = 1'b1,
	parameter int LOCAL_TIMEOUT_CYCLES = 64
) (
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RST_N_IN,
	// Configuration request from the transaction engine
	input wire logic CFG_RD_IN,
	input wire logic CFG_WR_IN,
	input wire pci_cfg_tail_pkg::dw_index_t CFG_DW_ADDR_IN,
	input wire logic [3:0] CFG_BYTE_ENA_IN,
	input wire logic [31:0] CFG_WR_DATA_IN,
	// Configuration answer
	output logic CFG_DONE_OUT,
	output logic [31:0] CFG_RD_DATA_OUT,
	output logic CFG_BUSY_OUT,
	// Forwarded accesses to local user logic
	output logic LOCAL_CFG_RD_OUT,
	output logic LOCAL_CFG_WR_OUT,
	output pci_cfg_tail_pkg::dw_index_t LOCAL_CFG_DW_ADDR_OUT,
	output logic [3:0] LOCAL_CFG_BYTE_ENA_OUT,
	output logic [31:0] LOCAL_CFG_WR_DATA_OUT,
	input wire logic LOCAL_CFG_ACK_IN,
	input wire logic [31:0] LOCAL_CFG_RD_DATA_IN,
	// Option ROM address lookup
	input wire logic ROM_LOOKUP_VALID_IN,
	input wire logic [31:0] ROM_LOOKUP_ADDR_IN,
	output logic ROM_HIT_OUT,
	// Interrupt routing for the system side
	output logic [7:0] IRQ_ROUTING_LINE_OUT
);
	import pci_cfg_tail_pkg::*;

	localparam int TMO_W = $clog2(LOCAL_TIMEOUT_CYCLES + 1);
	localparam logic [TMO_W-1:0] TMO_LAST =
		TMO_W'(LOCAL_TIMEOUT_CYCLES - 1);
	localparam logic [TMO_W-1:0] TMO_ZERO = '0;
	localparam logic [TMO_W-1:0] TMO_ONE = TMO_W'(1);
	localparam logic [7:0] IRQ_PIN_CODE = IRQ_ENABLE ? IRQ_PIN_INTA :
		IRQ_PIN_NONE;

	// Build-time checks
	if (CARD_PTR_ENABLE && (CARD_PTR_VALUE[CARD_SPACE_MSB:CARD_SPACE_LSB] ==
		CARD_SPACE_CONFIG)) begin : g_card_chk
		$error("Card info pointer may not select config space");
	end
	if (CAP_ENABLE && ((CAP_PTR_VALUE < CAP_PTR_MIN) ||
		(CAP_PTR_VALUE[1:0] != DW_ALIGN_ZERO))) begin : g_cap_chk
		$error("Capability pointer below 0x40 or unaligned");
	end
	if ((LOCAL_TIMEOUT_CYCLES < 1) || (LOCAL_TIMEOUT_CYCLES > 65535))
	begin : g_tmo_chk
		$error("Local timeout must be 1 to 65535 cycles");
	end

	fwd_state_t state_reg;
	logic [TMO_W-1:0] tmo_reg;
	logic fwd_is_rd_reg;
	logic [7:0] irq_line_reg;
	logic req;
	logic req_local;
	logic req_rd;
	logic take;
	logic rom_wr;
	logic [31:0] rom_value;
	logic [31:0] card_word;
	logic [31:0] subsys_word;
	logic [31:0] cap_word;
	logic [31:0] irq_word;
	logic [31:0] rd_value;
	logic local_done;
	logic local_tmo;

	// Read wins if the engine raises both strobes together
	assign req = CFG_RD_IN || CFG_WR_IN;
	assign req_rd = CFG_RD_IN;
	assign take = req && (state_reg == FWD_IDLE);
	assign req_local = (CFG_DW_ADDR_IN >= DW_LOCAL_START);
	assign rom_wr = take && !req_local && !req_rd &&
		(CFG_DW_ADDR_IN == DW_ROM_BASE);
	assign local_done = (state_reg == FWD_WAIT) && LOCAL_CFG_ACK_IN;
	assign local_tmo = (state_reg == FWD_WAIT) && !LOCAL_CFG_ACK_IN &&
		(tmo_reg == TMO_LAST);

	// Option ROM base register and decoder
	rom_bar_decoder #(
		.ROM_ENABLE(ROM_ENABLE),
		.ROM_SIZE_MASK(ROM_SIZE_MASK),
		.ROM_HARDWIRE(ROM_HARDWIRE),
		.ROM_HARD_BASE(ROM_HARD_BASE)
	) u_rom_bar (
		.clk_in(REF_CLK_IN),
		.rst_n_in(RST_N_IN),
		.wr_in(rom_wr),
		.wr_data_in(CFG_WR_DATA_IN),
		.byte_ena_in(CFG_BYTE_ENA_IN),
		.lookup_valid_in(ROM_LOOKUP_VALID_IN),
		.lookup_addr_in(ROM_LOOKUP_ADDR_IN),
		.value_out(rom_value),
		.hit_out(ROM_HIT_OUT)
	);

	// Read words for the locally held doublewords
	always_comb begin
		card_word = DATA_ZERO;
		if (CARD_PTR_ENABLE) begin
			card_word[CARD_SPACE_MSB:CARD_SPACE_LSB] =
				CARD_PTR_VALUE[CARD_SPACE_MSB:CARD_SPACE_LSB];
			card_word[CARD_OFFSET_MSB:CARD_OFFSET_LSB] =
				CARD_PTR_VALUE[CARD_OFFSET_MSB:CARD_OFFSET_LSB];
			card_word[CARD_ROM_IMAGE_MSB:CARD_ROM_IMAGE_LSB] =
				CARD_PTR_VALUE[CARD_ROM_IMAGE_MSB:CARD_ROM_IMAGE_LSB];
		end
	end

	always_comb begin
		subsys_word = DATA_ZERO;
		subsys_word[SUBSYS_MAKER_LSB +: 16] = SUBSYS_MAKER_CODE;
		subsys_word[SUBSYS_CODE_LSB +: 16] = SUBSYS_CODE;
	end

	always_comb begin
		cap_word = DATA_ZERO;
		if (CAP_ENABLE) begin
			cap_word[7:0] = CAP_PTR_VALUE;
		end
	end

	always_comb begin
		irq_word = DATA_ZERO;
		irq_word[IRQ_LINE_LSB +: 8] = irq_line_reg;
		irq_word[IRQ_PIN_LSB +: 8] = IRQ_PIN_CODE;
	end

	// Offsets this block does not hold read as zero
	always_comb begin
		if (CFG_DW_ADDR_IN == DW_CARD_PTR) begin
			rd_value = card_word;
		end else if (CFG_DW_ADDR_IN == DW_SUBSYS) begin
			rd_value = subsys_word;
		end else if (CFG_DW_ADDR_IN == DW_ROM_BASE) begin
			rd_value = rom_value;
		end else if (CFG_DW_ADDR_IN == DW_CAP_PTR) begin
			rd_value = cap_word;
		end else if (CFG_DW_ADDR_IN == DW_IRQ) begin
			rd_value = irq_word;
		end else begin
			rd_value = DATA_ZERO;
		end
	end

	// Interrupt routing line, written by system software after power-up
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			irq_line_reg <= IRQ_LINE_RST;
		end else if (take && !req_rd && !req_local &&
			(CFG_DW_ADDR_IN == DW_IRQ) &&
			CFG_BYTE_ENA_IN[IRQ_LINE_LSB / 8]) begin
			irq_line_reg <= CFG_WR_DATA_IN[IRQ_LINE_LSB +: 8];
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			IRQ_ROUTING_LINE_OUT <= IRQ_LINE_RST;
		end else begin
			IRQ_ROUTING_LINE_OUT <= irq_line_reg;
		end
	end

	// Forwarding sequencer; requests while busy are not taken
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg <= FWD_IDLE;
		end else begin
			case (state_reg)
				FWD_IDLE: begin
					if (take && req_local) begin
						state_reg <= FWD_WAIT;
					end
				end
				FWD_WAIT: begin
					if (local_done || local_tmo) begin
						state_reg <= FWD_IDLE;
					end
				end
				default: begin
					state_reg <= FWD_IDLE;
				end
			endcase
		end
	end

	// Guard against local logic that never answers
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			tmo_reg <= TMO_ZERO;
		end else if (state_reg == FWD_WAIT) begin
			tmo_reg <= tmo_reg + TMO_ONE;
		end else begin
			tmo_reg <= TMO_ZERO;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			fwd_is_rd_reg <= 1'b0;
		end else if (take && req_local) begin
			fwd_is_rd_reg <= req_rd;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			CFG_BUSY_OUT <= 1'b0;
		end else if (take && req_local) begin
			CFG_BUSY_OUT <= 1'b1;
		end else if (local_done || local_tmo) begin
			CFG_BUSY_OUT <= 1'b0;
		end
	end

	// Strobes to local logic last one cycle; the fields hold until next
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			LOCAL_CFG_RD_OUT <= 1'b0;
			LOCAL_CFG_WR_OUT <= 1'b0;
		end else begin
			LOCAL_CFG_RD_OUT <= take && req_local && req_rd;
			LOCAL_CFG_WR_OUT <= take && req_local && !req_rd;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			LOCAL_CFG_DW_ADDR_OUT <= DW_LOCAL_START;
			LOCAL_CFG_BYTE_ENA_OUT <= BYTE_ENA_ALL;
			LOCAL_CFG_WR_DATA_OUT <= DATA_ZERO;
		end else if (take && req_local) begin
			LOCAL_CFG_DW_ADDR_OUT <= CFG_DW_ADDR_IN;
			// Reads always fetch the whole doubleword
			LOCAL_CFG_BYTE_ENA_OUT <= req_rd ? BYTE_ENA_ALL :
				CFG_BYTE_ENA_IN;
			LOCAL_CFG_WR_DATA_OUT <= CFG_WR_DATA_IN;
		end
	end

	// Answer to the engine; local answers arrive one cycle after ack
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			CFG_DONE_OUT <= 1'b0;
		end else begin
			CFG_DONE_OUT <= (take && !req_local) || local_done ||
				local_tmo;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			CFG_RD_DATA_OUT <= DATA_ZERO;
		end else if (take && !req_local && req_rd) begin
			CFG_RD_DATA_OUT <= rd_value;
		end else if (local_done && fwd_is_rd_reg) begin
			CFG_RD_DATA_OUT <= LOCAL_CFG_RD_DATA_IN;
		end else if (local_tmo && fwd_is_rd_reg) begin
			CFG_RD_DATA_OUT <= DATA_TIMEOUT;
		end
	end
endmodule

// >>> tb/cfg_tail_checker.sv
// Assertions on the configuration header tail ports
`timescale 1ns/1ps
module cfg_tail_checker #(
	parameter int LOCAL_TIMEOUT_CYCLES = 64
) (
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RST_N_IN,
	// Request and answer
	input wire logic CFG_RD_IN,
	input wire logic CFG_WR_IN,
	input wire pci_cfg_tail_pkg::dw_index_t CFG_DW_ADDR_IN,
	input wire logic [3:0] CFG_BYTE_ENA_IN,
	input wire logic [31:0] CFG_WR_DATA_IN,
	input wire logic CFG_DONE_OUT,
	input wire logic [31:0] CFG_RD_DATA_OUT,
	input wire logic CFG_BUSY_OUT,
	// Local side
	input wire logic LOCAL_CFG_RD_OUT,
	input wire logic LOCAL_CFG_WR_OUT,
	input wire logic [3:0] LOCAL_CFG_BYTE_ENA_OUT,
	input wire logic LOCAL_CFG_ACK_IN,
	input wire logic [31:0] LOCAL_CFG_RD_DATA_IN,
	// Lookup and routing
	input wire logic ROM_LOOKUP_VALID_IN,
	input wire logic ROM_HIT_OUT,
	input wire logic [7:0] IRQ_ROUTING_LINE_OUT
);
	import pci_cfg_tail_pkg::*;
	logic [15:0] busy_cnt_reg;
	logic rd_fwd_reg;
	wire req = (CFG_RD_IN | CFG_WR_IN) & !CFG_BUSY_OUT;
	wire fwd_rd = LOCAL_CFG_RD_OUT | (rd_fwd_reg & !LOCAL_CFG_WR_OUT);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			busy_cnt_reg <= 16'h0;
		else
			busy_cnt_reg <= CFG_BUSY_OUT ? busy_cnt_reg + 16'h1 : 16'h0;
	end
	// Remembers whether the pending forward is a read
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			rd_fwd_reg <= 1'b0;
		else if (LOCAL_CFG_RD_OUT | LOCAL_CFG_WR_OUT)
			rd_fwd_reg <= LOCAL_CFG_RD_OUT;
	end
	sequence s_fwd_take;
		req && CFG_DW_ADDR_IN >= DW_LOCAL_START;
	endsequence
	sequence s_fwd_issue;
		(LOCAL_CFG_RD_OUT || LOCAL_CFG_WR_OUT) && CFG_BUSY_OUT;
	endsequence
	sequence s_ack;
		CFG_BUSY_OUT && LOCAL_CFG_ACK_IN;
	endsequence
	a_fwd_issue: assert property (s_fwd_take |=> s_fwd_issue)
		else $error("forward strobe missing");
	a_local_answer: assert property (req
		&& CFG_DW_ADDR_IN < DW_LOCAL_START
		|=> CFG_DONE_OUT && !LOCAL_CFG_RD_OUT && !LOCAL_CFG_WR_OUT)
		else $error("header access not answered locally");
	a_fwd_full_word: assert property (LOCAL_CFG_RD_OUT
		|-> LOCAL_CFG_BYTE_ENA_OUT == BYTE_ENA_ALL)
		else $error("forwarded read not a full word");
	// Local logic may answer in the strobe cycle itself
	a_strobe_pulse: assert property (s_fwd_issue
		|=> !LOCAL_CFG_RD_OUT && !LOCAL_CFG_WR_OUT
		&& (CFG_DONE_OUT == ($past(LOCAL_CFG_ACK_IN) ||
		LOCAL_TIMEOUT_CYCLES == 1)))
		else $error("forward strobe too long");
	a_ack_done: assert property (s_ack
		|=> CFG_DONE_OUT && !CFG_BUSY_OUT)
		else $error("ack not answered");
	a_ack_data: assert property (s_ack ##0 fwd_rd
		|=> CFG_RD_DATA_OUT == $past(LOCAL_CFG_RD_DATA_IN))
		else $error("local read data lost");
	a_busy_bound: assert property (CFG_BUSY_OUT
		|-> busy_cnt_reg < LOCAL_TIMEOUT_CYCLES)
		else $error("forward wait too long");
	a_timeout_data: assert property (CFG_BUSY_OUT && !LOCAL_CFG_ACK_IN
		&& fwd_rd && busy_cnt_reg == LOCAL_TIMEOUT_CYCLES - 1
		|=> CFG_DONE_OUT && CFG_RD_DATA_OUT == DATA_TIMEOUT)
		else $error("timeout answer wrong");
	a_irq_line_copy: assert property (req && !CFG_RD_IN
		&& CFG_DW_ADDR_IN == DW_IRQ && CFG_BYTE_ENA_IN[0]
		|=> ##1 IRQ_ROUTING_LINE_OUT == $past(CFG_WR_DATA_IN[7:0], 2))
		else $error("routing line not updated");
	a_hit_cause: assert property (ROM_HIT_OUT
		|-> $past(ROM_LOOKUP_VALID_IN))
		else $error("claim without lookup");
endmodule

// >>> tb/local_cap_model.sv
// Local user logic holding capability registers
`timescale 1ns/1ps
module local_cap_model (
	// Clock
	input wire logic clk_in,
	// Forwarded access
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [5:0] idx_in,
	input wire logic [3:0] be_in,
	input wire logic [31:0] wdata_in,
	// Answer pacing
	input wire logic [3:0] delay_in,
	input wire logic mute_in,
	// Answer
	output logic ack_out,
	output logic [31:0] rd_data_out
);
	logic [31:0] mem_reg [0:7];
	logic [3:0] cnt_reg;
	logic pend_reg;
	logic [2:0] slot_reg;
	initial begin
		ack_out = 1'b0;
		rd_data_out = 32'h0;
		pend_reg = 1'b0;
	end
	// Data not held outside the ack cycle
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		rd_data_out <= ~rd_data_out;
		if (rd_in | wr_in) begin
			pend_reg <= !mute_in;
			cnt_reg <= delay_in;
			slot_reg <= idx_in[2:0];
			for (int i = 0; i < 4; i++)
				if (wr_in && be_in[i])
					mem_reg[idx_in[2:0]][8*i+:8] <= wdata_in[8*i+:8];
		end else if (pend_reg && cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end else if (pend_reg) begin
			ack_out <= 1'b1;
			rd_data_out <= mem_reg[slot_reg];
			pend_reg <= 1'b0;
		end
	end
endmodule

// >>> tb/pci_config_header_tail_regs_tb.sv
// Self-checking bench for the configuration header tail
`timescale 1ns/1ps
module pci_config_header_tail_regs_tb;
	import pci_cfg_tail_pkg::*;
	localparam logic [31:0] CARD_V = 32'h1234_5672;
	localparam logic [7:0] CAP_V = 8'h48;
	localparam logic [31:0] MASK = 32'hFFFF_0000;
	// Hardwired base of the second instance, aligned to MASK
	localparam logic [31:0] HBASE = 32'h00AB_0000;
	localparam logic [15:0] MAKER = 16'h1357;
	localparam logic [15:0] SUBSYS = 16'h2468;
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, lv = 1'b0;
	logic done, busy, lrd, lwr, ack, hit, mute = 1'b0;
	logic done2, hit2;
	logic [31:0] rdat2, rom2;
	logic [7:0] line2;
	dw_index_t idx = 6'h00, lidx;
	logic [3:0] be = 4'h0, lbe, dly = 4'h0;
	logic [31:0] wd = 32'h0, la = 32'h0, rdat, lwd, ldat, d, a, rom;
	logic [7:0] line;
	int n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'hd89c;
	dw_index_t ro_a[5] = '{6'h0A, 6'h0B, 6'h0D, 6'h0E, 6'h0F};
	logic [31:0] ro_v[5] = '{CARD_V, {SUBSYS, MAKER}, {24'h0, CAP_V}, 32'h0,
		32'h0000_0100};
	// Second instance: pointer, capabilities and interrupt pin disabled
	logic [31:0] ro_v2[5] = '{32'h0, {SUBSYS, MAKER}, 32'h0, 32'h0, 32'h0};
	pci_config_header_tail_regs #(.CARD_PTR_ENABLE(1'b1),
		.CARD_PTR_VALUE(CARD_V), .SUBSYS_MAKER_CODE(MAKER),
		.SUBSYS_CODE(SUBSYS), .CAP_ENABLE(1'b1), .CAP_PTR_VALUE(CAP_V),
		.LOCAL_TIMEOUT_CYCLES(8)) dut (
		.REF_CLK_IN(clk), .RST_N_IN(rst_n),
		.CFG_RD_IN(rd), .CFG_WR_IN(wr), .CFG_DW_ADDR_IN(idx),
		.CFG_BYTE_ENA_IN(be), .CFG_WR_DATA_IN(wd),
		.CFG_DONE_OUT(done), .CFG_RD_DATA_OUT(rdat), .CFG_BUSY_OUT(busy),
		.LOCAL_CFG_RD_OUT(lrd), .LOCAL_CFG_WR_OUT(lwr),
		.LOCAL_CFG_DW_ADDR_OUT(lidx), .LOCAL_CFG_BYTE_ENA_OUT(lbe),
		.LOCAL_CFG_WR_DATA_OUT(lwd), .LOCAL_CFG_ACK_IN(ack),
		.LOCAL_CFG_RD_DATA_IN(ldat), .ROM_LOOKUP_VALID_IN(lv),
		.ROM_LOOKUP_ADDR_IN(la), .ROM_HIT_OUT(hit),
		.IRQ_ROUTING_LINE_OUT(line));
	// Hardwired ROM, no interrupt; shares requests and local answers
	pci_config_header_tail_regs #(.SUBSYS_MAKER_CODE(MAKER),
		.SUBSYS_CODE(SUBSYS), .ROM_HARDWIRE(1'b1), .ROM_HARD_BASE(HBASE),
		.IRQ_ENABLE(1'b0), .LOCAL_TIMEOUT_CYCLES(8)) dut2 (
		.REF_CLK_IN(clk), .RST_N_IN(rst_n),
		.CFG_RD_IN(rd), .CFG_WR_IN(wr), .CFG_DW_ADDR_IN(idx),
		.CFG_BYTE_ENA_IN(be), .CFG_WR_DATA_IN(wd),
		.CFG_DONE_OUT(done2), .CFG_RD_DATA_OUT(rdat2), .CFG_BUSY_OUT(),
		.LOCAL_CFG_RD_OUT(), .LOCAL_CFG_WR_OUT(),
		.LOCAL_CFG_DW_ADDR_OUT(), .LOCAL_CFG_BYTE_ENA_OUT(),
		.LOCAL_CFG_WR_DATA_OUT(), .LOCAL_CFG_ACK_IN(ack),
		.LOCAL_CFG_RD_DATA_IN(ldat), .ROM_LOOKUP_VALID_IN(lv),
		.ROM_LOOKUP_ADDR_IN(la), .ROM_HIT_OUT(hit2),
		.IRQ_ROUTING_LINE_OUT(line2));
	local_cap_model model (.clk_in(clk), .rd_in(lrd), .wr_in(lwr),
		.idx_in(lidx), .be_in(lbe), .wdata_in(lwd), .delay_in(dly),
		.mute_in(mute), .ack_out(ack), .rd_data_out(ldat));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic complete_run();
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Generous ceiling; the sequence needs under 2000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
		end
	endtask
	// One edge passes first, so a strobe is never lowered and raised at once
	task automatic cfg(input logic r, input dw_index_t i,
		input logic [3:0] b, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk) #1;
		rd = r;
		wr = !r;
		idx = i;
		be = b;
		wd = v;
		@(posedge clk) #1;
		rd = 1'b0;
		wr = 1'b0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge clk) #1;
			n++;
		end
		chk_bit(done, 1'b1);
		chk_bit(done2, 1'b1);
	endtask
	task automatic look(input logic [31:0] v, input logic e, e2);
		@(posedge clk) #1;
		lv = 1'b1;
		la = v;
		@(posedge clk) #1;
		lv = 1'b0;
		chk_bit(hit, e);
		chk_bit(hit2, e2);
	endtask
	function automatic logic exp_hit(input logic [31:0] v, r);
		return r[0] && ((v & MASK) == (r & MASK));
	endfunction
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(line, 8'h00);
		chk(line2, 8'h00);
		// Hardwired window claims before any setup; the other stays off
		look(HBASE | 32'h0000_1234, 1'b0, 1'b1);
		for (int i = 0; i < 5; i++) begin
			cfg(1'b0, ro_a[i], 4'hE, 32'hFFFF_FFFF);
			cfg(1'b1, ro_a[i], 4'hF, 32'h0);
			chk(rdat, ro_v[i]);
			chk(rdat2, ro_v2[i]);
		end
		cfg(1'b1, DW_ROM_BASE, 4'hF, 32'h0);
		chk(rdat, 32'h0);
		chk(rdat2, HBASE | 32'h1);
		cfg(1'b0, DW_ROM_BASE, 4'hF, 32'hFFFF_FFFF);
		cfg(1'b1, DW_ROM_BASE, 4'hF, 32'h0);
		chk(rdat, MASK | 32'h1);
		chk(rdat2, HBASE | 32'h1);
		rom = MASK | 32'h1;
		rom2 = HBASE | 32'h1;
		for (int i = 0; i < 48; i++) begin
			if (i % 8 == 0) begin
				d = $random(seed);
				cfg(1'b0, DW_ROM_BASE, 4'hF, d);
				rom = (d & MASK) | {31'h0, d[0]};
				rom2 = HBASE | {31'h0, d[0]};
				cfg(1'b1, DW_ROM_BASE, 4'hF, 32'h0);
				chk(rdat, rom);
				chk(rdat2, rom2);
			end
			a = $random(seed);
			if (i[0])
				a = (rom & MASK) | (a & ~MASK);
			else if (i[1])
				a = HBASE | (a & ~MASK);
			look(a, exp_hit(a, rom), exp_hit(a, rom2));
		end
		d = $random(seed);
		cfg(1'b0, DW_IRQ, 4'h1, d);
		cfg(1'b0, DW_IRQ, 4'hE, ~d);
		cfg(1'b1, DW_IRQ, 4'hF, 32'h0);
		chk(rdat, {16'h0, IRQ_PIN_INTA, d[7:0]});
		chk(line, d[7:0]);
		chk(rdat2, {16'h0, IRQ_PIN_NONE, d[7:0]});
		chk(line2, d[7:0]);
		// Ack delays up to just inside the wait limit
		for (int i = 0; i < 6; i++) begin
			dly = i[3:0];
			d = $random(seed);
			cfg(1'b0, DW_LOCAL_START + 6'(i), 4'hF, d);
			cfg(1'b1, DW_LOCAL_START + 6'(i), 4'h3, 32'h0);
			chk(rdat, d);
			chk(rdat2, d);
		end
		mute = 1'b1;
		cfg(1'b1, 6'h3F, 4'hF, 32'h0);
		chk(rdat, DATA_TIMEOUT);
		chk(rdat2, DATA_TIMEOUT);
		mute = 1'b0;
		cfg(1'b1, DW_CAP_PTR, 4'hF, 32'h0);
		chk(rdat, {24'h0, CAP_V});
		chk(rdat2, 32'h0);
		complete_run();
	end
endmodule
bind pci_config_header_tail_regs cfg_tail_checker #(
	.LOCAL_TIMEOUT_CYCLES(LOCAL_TIMEOUT_CYCLES)) u_chk (.*);
